// ### rtl/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// Behaviour
// - Module-on bit enables block and claims pins
// - Halt-in-idle stops block during processor idle
// - Slave enhanced count shows unread transfers
// - Shifter-empty flag is one while shifter idle
// - Overflow flag set, new word discarded
// - Receive-FIFO-empty flag mirrors receive FIFO contents
// - Select 110: last bit in, TX empty
// - Select 101: last bit out, transfer done
// - Select 100: word moved into the shifter
// - Select 000: last receive entry read out
// - Standard TX full: set on write, cleared on load
// - Standard RX full: set on receive, cleared on read

// ==========================================================
// Register byte offsets
`define SSC_OFF_STAT   12'h000
`define SSC_OFF_DATA   12'h004
`define SSC_OFF_CTRL   12'h008
`define SSC_OFF_ISTAT  12'h00c
`define SSC_OFF_IMASK  12'h010

// ==========================================================
// Status and control field positions
`define SSC_BIT_ON     15
`define SSC_BIT_SIDL   13
`define SSC_BEC_HI     10
`define SSC_BEC_LO     8
`define SSC_BIT_SHIFTER_EMPTY_FLAG  7
`define SSC_BIT_ROV    6
`define SSC_BIT_RXMPT  5
`define SSC_SEL_HI     4
`define SSC_SEL_LO     2
`define SSC_BIT_TBF    1
`define SSC_BIT_RBF    0
`define SSC_BIT_MASTER 0
`define SSC_BIT_ENH    1
`define SSC_IRQ_BUF    0
`define SSC_IRQ_ROV    1

// ==========================================================
// Buffer interrupt select codes
`define SSC_SEL_RX_EMPTY 3'h0
`define SSC_SEL_RX_ANY   3'h1
`define SSC_SEL_RX_HALF  3'h2
`define SSC_SEL_RX_FULL  3'h3
`define SSC_SEL_TX_FREE  3'h4
`define SSC_SEL_TX_DONE  3'h5
`define SSC_SEL_TX_EMPTY 3'h6
`define SSC_SEL_TX_FULL  3'h7

// ==========================================================
// Reset values
`define SSC_RST_ON     1'h0
`define SSC_RST_SIDL   1'h0
`define SSC_RST_BUFFER_IRQ_SELECT  3'h0
`define SSC_RST_MASTER 1'h0
`define SSC_RST_ENH    1'h0
`define SSC_RST_IMASK  2'h0

// ==========================================================
// Timing
`define SSC_CLK_NS       10
`define SSC_SCK_HALF_NS  80
`define SSC_SCK_HALF_CYC ((`SSC_SCK_HALF_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)

`endif

// ### rtl/ssc_pkg.sv
package ssc_pkg;

  // ==========================================================
  // Levels sensed on the serial pins
  typedef struct packed {
    logic serial_clock_pin;
    logic serial_in_pin;
    logic select_or_frame_pin_n;
  } ssc_pin_sense_t;

  // ==========================================================
  // Levels and enables driven onto the serial pins
  typedef struct packed {
    logic serial_clock_pin;
    logic serial_clock_oe;
    logic serial_out_pin;
    logic serial_out_oe;
  } ssc_pin_drive_t;

  // Shifter states
  typedef enum logic {
    SSC_IDLE,
    SSC_SHIFT
  } ssc_shift_st_t;

endpackage

// ### rtl/ssc_sync.sv
`timescale 1ns/1ps
module ssc_sync
#(
  parameter int W = 3
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Raw and retimed levels
  input  wire logic [W-1:0] raw_lvl,
  output logic      [W-1:0] sync_lvl
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssc_sync_state_t;

  ssc_sync_state_t s_q;
  ssc_sync_state_t s_d;

  // ==========================================================
  // Two stages; only the second stage is visible outside
  always_comb
  begin
    s_d        = s_q;
    s_d.meta   = raw_lvl;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_lvl = s_q.stable;

endmodule

// ### rtl/ssc_core.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_core
#(
  parameter int DW    = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 12,
  parameter int HALF  = `SSC_SCK_HALF_CYC
)
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [AW-1:0]           paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Processor power state
  input  wire logic                    cpu_idle,
  // Serial pins
  input  wire ssc_pkg::ssc_pin_sense_t pin_sense,
  output ssc_pkg::ssc_pin_drive_t      pin_drive,
  // Interrupt
  output logic                         irq
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int BW = (DW > 1) ? $clog2(DW) : 1;
  localparam int HW = $clog2(HALF + 1);

  typedef struct packed {
    logic                   en;
    logic                   sidl;
    logic [2:0]             buffer_irq_select;
    logic                   rov;
    logic                   master;
    logic                   enh;
    logic [1:0]             istat;
    logic [1:0]             imask;
    logic                   irq;
    logic                   lvl_prev;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [DEPTH-1:0][DW-1:0] txf;
    logic [DEPTH-1:0][DW-1:0] rxf;
    logic [PW-1:0]          tx_rd;
    logic [PW-1:0]          tx_wr;
    logic [PW-1:0]          rx_rd;
    logic [PW-1:0]          rx_wr;
    logic [CW-1:0]          tx_cnt;
    logic [CW-1:0]          rx_cnt;
    ssc_pkg::ssc_shift_st_t st;
    logic [DW-1:0]          sr;
    logic                   rx_bit;
    logic [BW-1:0]          bitcnt;
    logic [HW-1:0]          div;
    logic                   sck;
    logic                   sck_prev;
    logic                   sck_oe;
    logic                   sdo_oe;
  } ssc_state_t;

  ssc_state_t    s_q;
  ssc_state_t    s_d;
  logic [2:0]    pin_s;
  logic          sck_s;
  logic          sdi_s;
  logic          ss_n_s;
  logic          setup;
  logic          access;
  logic          wr_acc;
  logic          rd_acc;
  logic [CW-1:0] cap;
  logic          tx_full;
  logic          tx_empty;
  logic          rx_full;
  logic          rx_empty;
  logic          halted;
  logic          run;
  logic          push_tx;
  logic          pop_rx;
  logic [CW-1:0] bec;
  logic [15:0]   stat_rd;
  logic [31:0]   rd_mux;
  logic          hit;
  logic [DW-1:0] word;
  logic          rise;
  logic          fall;
  logic          tick;
  logic          load_ev;
  logic          done_ev;
  logic          out_ev;
  logic          push_rx;
  logic          ovf_ev;
  logic          buf_lvl;
  logic          buf_pulse;
  logic          buf_ev;
  logic          stat_wr;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // ==========================================================
  // Pin retiming: link clock, data in and select pass two flops
  ssc_sync #(
    .W (3)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .raw_lvl  ({pin_sense.serial_clock_pin, pin_sense.serial_in_pin,
                pin_sense.select_or_frame_pin_n}),
    .sync_lvl (pin_s)
  );

  assign sck_s  = pin_s[2];
  assign sdi_s  = pin_s[1];
  assign ss_n_s = pin_s[0];

  // ==========================================================
  // Bus phases and buffer levels
  assign setup    = psel & ~penable;
  assign access   = psel & penable & s_q.pready;
  assign wr_acc   = access & pwrite;
  assign rd_acc   = access & ~pwrite;
  assign stat_wr  = wr_acc & (paddr == `SSC_OFF_STAT);
  assign cap      = s_q.enh ? CW'(DEPTH) : CW'(1);
  assign tx_full  = (s_q.tx_cnt >= cap);
  assign tx_empty = (s_q.tx_cnt == '0);
  assign rx_full  = (s_q.rx_cnt >= cap);
  assign rx_empty = (s_q.rx_cnt == '0);
  assign halted   = s_q.sidl & cpu_idle;
  assign run      = s_q.en & ~halted;
  // A write to a full transmit buffer is dropped, never overwrites
  assign push_tx  = wr_acc & (paddr == `SSC_OFF_DATA) & s_q.en & ~tx_full;
  assign pop_rx   = rd_acc & (paddr == `SSC_OFF_DATA) & s_q.en & ~rx_empty;
  assign bec      = s_q.master ? s_q.tx_cnt : s_q.rx_cnt;
  assign word     = {s_q.sr[DW-2:0], s_q.rx_bit};
  assign tick     = (s_q.div == HW'(HALF - 1));

  // ==========================================================
  // Status word as software sees it; unlisted bits stay zero
  always_comb
  begin
    stat_rd                           = '0;
    stat_rd[`SSC_BIT_ON]              = s_q.en;
    stat_rd[`SSC_BIT_SIDL]            = s_q.sidl;
    if (s_q.enh)
    begin
      stat_rd[`SSC_BEC_HI:`SSC_BEC_LO] = 3'(bec);
    end
    stat_rd[`SSC_BIT_SHIFTER_EMPTY_FLAG]           = (s_q.st == ssc_pkg::SSC_IDLE);
    stat_rd[`SSC_BIT_ROV]             = s_q.rov;
    stat_rd[`SSC_BIT_RXMPT]           = rx_empty;
    stat_rd[`SSC_SEL_HI:`SSC_SEL_LO]  = s_q.buffer_irq_select;
    stat_rd[`SSC_BIT_TBF]             = tx_full;
    stat_rd[`SSC_BIT_RBF]             = rx_full;
  end

  // Read multiplexer; unmapped addresses answer zero with an error
  always_comb
  begin
    rd_mux = '0;
    hit    = 1'b1;
    case (paddr)
      `SSC_OFF_STAT:  rd_mux = 32'(stat_rd);
      `SSC_OFF_DATA:  rd_mux = 32'(s_q.rxf[s_q.rx_rd]);
      `SSC_OFF_CTRL:  rd_mux = 32'({s_q.enh, s_q.master});
      `SSC_OFF_ISTAT: rd_mux = 32'(s_q.istat);
      `SSC_OFF_IMASK: rd_mux = 32'(s_q.imask);
      default:        hit    = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d       = s_q;
    rise      = 1'b0;
    fall      = 1'b0;
    load_ev   = 1'b0;
    done_ev   = 1'b0;
    out_ev    = 1'b0;
    push_rx   = 1'b0;
    ovf_ev    = 1'b0;
    buf_lvl   = 1'b0;
    buf_pulse = 1'b0;
    // Data is prepared in setup so the access phase has no wait state
    s_d.pready  = setup;
    s_d.pslverr = setup & ~hit;
    s_d.prdata  = setup ? rd_mux : '0;
    if (stat_wr)
    begin
      s_d.en    = pwdata[`SSC_BIT_ON];
      s_d.sidl  = pwdata[`SSC_BIT_SIDL];
      s_d.buffer_irq_select = pwdata[`SSC_SEL_HI:`SSC_SEL_LO];
    end
    if (wr_acc && (paddr == `SSC_OFF_CTRL))
    begin
      s_d.master = pwdata[`SSC_BIT_MASTER];
      s_d.enh    = pwdata[`SSC_BIT_ENH];
    end
    if (wr_acc && (paddr == `SSC_OFF_IMASK))
    begin
      s_d.imask = pwdata[1:0];
    end
    if (push_tx)
    begin
      s_d.txf[s_q.tx_wr] = pwdata[DW-1:0];
      s_d.tx_wr          = nxt(s_q.tx_wr);
    end
    if (pop_rx)
    begin
      s_d.rx_rd = nxt(s_q.rx_rd);
    end
    s_d.sck_prev = sck_s;
    // Shifter, mode 0: sample on rising edge, shift on falling edge
    case (s_q.st)
      ssc_pkg::SSC_IDLE:
      begin
        s_d.bitcnt = '0;
        s_d.div    = '0;
        if (run && s_q.master && !tx_empty)
        begin
          s_d.sr    = s_q.txf[s_q.tx_rd];
          s_d.tx_rd = nxt(s_q.tx_rd);
          load_ev   = 1'b1;
          s_d.st    = ssc_pkg::SSC_SHIFT;
        end
        else if (run && !s_q.master && !ss_n_s)
        begin
          // Slave with nothing queued shifts out zeros
          s_d.sr = tx_empty ? '0 : s_q.txf[s_q.tx_rd];
          if (!tx_empty)
          begin
            s_d.tx_rd = nxt(s_q.tx_rd);
            load_ev   = 1'b1;
          end
          s_d.st = ssc_pkg::SSC_SHIFT;
        end
      end
      ssc_pkg::SSC_SHIFT:
      begin
        if (!s_q.master && ss_n_s)
        begin
          s_d.st = ssc_pkg::SSC_IDLE;
          out_ev = 1'b1;
        end
        else if (run)
        begin
          if (s_q.master)
          begin
            s_d.div = tick ? '0 : HW'(s_q.div + 1'b1);
            s_d.sck = tick ? ~s_q.sck : s_q.sck;
            rise    = tick & ~s_q.sck;
            fall    = tick & s_q.sck;
          end
          else
          begin
            rise = sck_s & ~s_q.sck_prev;
            fall = ~sck_s & s_q.sck_prev;
          end
          if (rise)
          begin
            s_d.rx_bit = sdi_s;
          end
          if (fall)
          begin
            s_d.sr = word;
            if (s_q.bitcnt == BW'(DW - 1))
            begin
              done_ev    = 1'b1;
              s_d.bitcnt = '0;
              // A full receive buffer keeps its data; the new word is lost
              if (rx_full && !pop_rx)
              begin
                ovf_ev = 1'b1;
              end
              else
              begin
                push_rx = 1'b1;
              end
              if (s_q.master)
              begin
                s_d.st = ssc_pkg::SSC_IDLE;
                out_ev = 1'b1;
              end
              else if (!tx_empty)
              begin
                s_d.sr    = s_q.txf[s_q.tx_rd];
                s_d.tx_rd = nxt(s_q.tx_rd);
                load_ev   = 1'b1;
              end
            end
            else
            begin
              s_d.bitcnt = BW'(s_q.bitcnt + 1'b1);
            end
          end
        end
      end
      default:
      begin
        s_d.st = ssc_pkg::SSC_IDLE;
      end
    endcase
    if (push_rx)
    begin
      s_d.rxf[s_q.rx_wr] = word;
      s_d.rx_wr          = nxt(s_q.rx_wr);
    end
    s_d.tx_cnt = CW'(s_q.tx_cnt + CW'(push_tx) - CW'(load_ev));
    s_d.rx_cnt = CW'(s_q.rx_cnt + CW'(push_rx) - CW'(pop_rx));
    // Clearing the module-on bit flushes buffers and stops the shifter
    if (!s_q.en)
    begin
      s_d.tx_cnt = '0;
      s_d.rx_cnt = '0;
      s_d.tx_rd  = '0;
      s_d.tx_wr  = '0;
      s_d.rx_rd  = '0;
      s_d.rx_wr  = '0;
      s_d.st     = ssc_pkg::SSC_IDLE;
      s_d.sck    = 1'b0;
    end
    // Overflow: set wins over a software clear in the same cycle
    s_d.rov = ovf_ev | (s_q.rov & ~(stat_wr & ~pwdata[`SSC_BIT_ROV]));
    // Buffer interrupt condition picked by the select field
    case (s_q.buffer_irq_select)
      `SSC_SEL_TX_FULL:  buf_lvl   = tx_full;
      `SSC_SEL_RX_FULL:  buf_lvl   = rx_full;
      `SSC_SEL_RX_HALF:  buf_lvl   = ({s_q.rx_cnt, 1'b0} >= {1'b0, cap}) & ~rx_empty;
      `SSC_SEL_RX_ANY:   buf_lvl   = ~rx_empty;
      `SSC_SEL_TX_EMPTY: buf_pulse = done_ev & (s_d.tx_cnt == '0);
      `SSC_SEL_TX_DONE:  buf_pulse = out_ev;
      `SSC_SEL_TX_FREE:  buf_pulse = load_ev;
      `SSC_SEL_RX_EMPTY: buf_pulse = pop_rx & (s_d.rx_cnt == '0);
      default:           buf_pulse = 1'b0;
    endcase
    buf_ev       = s_q.en & (buf_pulse | (buf_lvl & ~s_q.lvl_prev));
    s_d.lvl_prev = buf_lvl;
    // Read clears only the bits that were returned, so a new event survives
    s_d.istat = s_q.istat & ~((rd_acc && (paddr == `SSC_OFF_ISTAT)) ? s_q.prdata[1:0] : 2'h0);
    s_d.istat[`SSC_IRQ_BUF] = s_d.istat[`SSC_IRQ_BUF] | buf_ev;
    s_d.istat[`SSC_IRQ_ROV] = s_d.istat[`SSC_IRQ_ROV] | ovf_ev;
    s_d.irq    = |(s_d.istat & s_d.imask);
    s_d.sck_oe = s_d.en & s_d.master;
    s_d.sdo_oe = s_d.en & (s_d.master | ~ss_n_s);
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q        <= '0;
      s_q.en     <= `SSC_RST_ON;
      s_q.sidl   <= `SSC_RST_SIDL;
      s_q.buffer_irq_select  <= `SSC_RST_BUFFER_IRQ_SELECT;
      s_q.master <= `SSC_RST_MASTER;
      s_q.enh    <= `SSC_RST_ENH;
      s_q.imask  <= `SSC_RST_IMASK;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata                     = s_q.prdata;
  assign pready                     = s_q.pready;
  assign pslverr                    = s_q.pslverr;
  assign irq                        = s_q.irq;
  assign pin_drive.serial_clock_pin = s_q.sck;
  assign pin_drive.serial_clock_oe  = s_q.sck_oe;
  assign pin_drive.serial_out_pin   = s_q.sr[DW-1];
  assign pin_drive.serial_out_oe    = s_q.sdo_oe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence master_word_s;
    (load_ev && s_q.master) ##1 (s_q.st == ssc_pkg::SSC_SHIFT) [*2];
  endsequence

  unimpl_zero_a: assert property ((pready && !pwrite && paddr == `SSC_OFF_STAT) |->
      (prdata[14] == 1'b0 && prdata[12:11] == 2'h0 && prdata[31:16] == 16'h0))
    else $error("Unimplemented status bits read nonzero");
  off_pins_a: assert property (!s_q.en |-> (!pin_drive.serial_clock_oe &&
      !pin_drive.serial_out_oe) ##1 (s_q.st == ssc_pkg::SSC_IDLE))
    else $error("Disabled module still owns pins");
  idle_halt_a: assert property ((s_q.st == ssc_pkg::SSC_SHIFT && halted) |=>
      ($stable(s_q.sr) && $stable(s_q.bitcnt)))
    else $error("Shifter moved while halted in idle");
  bec_master_a: assert property ((s_q.enh && s_q.master && push_tx && !load_ev) |=>
      (stat_rd[10:8] == 3'($past(stat_rd[10:8]) + 3'h1)))
    else $error("Pending count did not grow on write");
  bec_slave_a: assert property ((s_q.enh && !s_q.master && push_rx && !pop_rx) |=>
      (!s_q.en || stat_rd[10:8] == 3'($past(stat_rd[10:8]) + 3'h1)))
    else $error("Unread count did not grow on receive");
  shifter_empty_flag_busy_a: assert property (master_word_s |-> !stat_rd[`SSC_BIT_SHIFTER_EMPTY_FLAG])
    else $error("Shifter-empty set while shifting");
  ovf_drop_a: assert property ((done_ev && rx_full && !pop_rx) |=>
      (s_q.rov && (!s_q.en || s_q.rx_cnt == $past(s_q.rx_cnt))))
    else $error("Overflow not flagged or word not discarded");
  rx_empty_a: assert property (push_rx |=> (!s_q.en || !stat_rd[`SSC_BIT_RXMPT]))
    else $error("Receive-empty flag stuck after receive");
  sel_in_a: assert property ((s_q.en && s_q.buffer_irq_select == `SSC_SEL_TX_EMPTY && done_ev &&
      tx_empty && !push_tx) |=> s_q.istat[`SSC_IRQ_BUF])
    else $error("No interrupt after last bit in");
  sel_out_a: assert property ((s_q.en && s_q.buffer_irq_select == `SSC_SEL_TX_DONE && out_ev)
      |=> (s_q.istat[`SSC_IRQ_BUF] && (irq || !s_q.imask[`SSC_IRQ_BUF])))
    else $error("No interrupt after transfer complete");
  sel_free_a: assert property ((s_q.en && s_q.buffer_irq_select == `SSC_SEL_TX_FREE && load_ev)
      |=> s_q.istat[`SSC_IRQ_BUF])
    else $error("No interrupt on word move into shifter");
  sel_drain_a: assert property ((s_q.buffer_irq_select == `SSC_SEL_RX_EMPTY && pop_rx &&
      s_q.rx_cnt == CW'(1) && !push_rx) |=> (s_q.istat[`SSC_IRQ_BUF] && stat_rd[5]))
    else $error("No interrupt on receive buffer drained");
  sel_full_a: assert property ((s_q.en && s_q.buffer_irq_select == `SSC_SEL_TX_FULL && tx_full &&
      !s_q.lvl_prev) |=> s_q.istat[`SSC_IRQ_BUF])
    else $error("No interrupt on transmit full");
  tbf_std_a: assert property ((!s_q.enh && push_tx && !load_ev) |=> stat_rd[1])
    else $error("Transmit full not set on write");
  rbf_std_a: assert property ((!s_q.enh && pop_rx && !push_rx) |=> !stat_rd[0])
    else $error("Receive full not cleared on read");

endmodule

// ### sim/ssc_peer.sv
`timescale 1ns/1ps
module ssc_peer
(
  // Serial link from the master
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0] sh_in  = 8'h00;
  logic [7:0] sh_out = 8'h3c;
  int         n      = 0;

  // ==========================================================
  // Mode 0 slave: MSB waits before the first rise
  initial miso = 1'b0;

  // Sample on rise; a whole word is answered with itself xor 5a next time
  always @(posedge sck)
  begin
    sh_in = {sh_in[6:0], mosi};
    n     = n + 1;
    if (n == 8)
    begin
      n      = 0;
      sh_out = sh_in ^ 8'h5a;
      miso   = sh_out[7];
    end
  end

  // Shift on fall inside a word only, so the next MSB stands between words
  always @(negedge sck)
  begin
    if (n != 0)
    begin
      sh_out = {sh_out[6:0], 1'b0};
      miso   = sh_out[7];
    end
  end
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module testbench;
  logic                    pclk     = 1'b0;
  logic                    presetn  = 1'b0;
  logic                    psel     = 1'b0;
  logic                    penable  = 1'b0;
  logic                    pwrite   = 1'b0;
  logic [11:0]             paddr    = 12'h000;
  logic [31:0]             pwdata   = 32'h0;
  logic                    cpu_idle = 1'b0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  logic                    miso;
  ssc_pkg::ssc_pin_sense_t pin_sense;
  ssc_pkg::ssc_pin_drive_t pin_drive;
  int                      n_fail    = 0;
  int                      tests_run = 0;
  logic [7:0]              seed      = 8'h0c;
  logic [7:0]              peer_next = 8'h3c;
  logic [7:0]              q[$];
  logic [31:0]             rd;
  logic                    err;
  logic                    sck_m    = 1'b0;
  logic                    mosi_m   = 1'b0;
  logic                    ss_n     = 1'b1;
  logic                    slave    = 1'b0;
  logic [7:0]              got;
  logic [7:0]              sb[3];
  logic [2:0]              sels[3]  = '{3'h4, 3'h6, 3'h5};

  // ==========================================================
  // Clock, pins and instances
  always #5 pclk = ~pclk;
  // Bench plays link master in the slave test; otherwise the peer answers
  assign pin_sense = '{serial_clock_pin: sck_m, serial_in_pin: slave ? mosi_m : miso,
                       select_or_frame_pin_n: ss_n};

  ssc_core #(.DW(8), .DEPTH(4), .AW(12), .HALF(8)) ssc_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .pin_sense(pin_sense), .pin_drive(pin_drive), .irq(irq));
  ssc_peer ssc_peer_inst (.sck(pin_drive.serial_clock_pin), .mosi(pin_drive.serial_out_pin),
    .miso(miso));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; only the bench watchdog bounds the wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  // Push a random byte; the peer answers with its earlier word
  task automatic send();
    seed = lfsr(seed);
    q.push_back(peer_next);
    peer_next = seed ^ 8'h5a;
    apb(1'b1, `SSC_OFF_DATA, {24'h0, seed});
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 1000)
    begin
      @(posedge pclk);
      k++;
    end
    chk("irq_level", {31'h0, irq}, 32'h1);
  endtask

  // Poll until nothing is queued and the shifter is empty
  task automatic wait_done();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `SSC_OFF_STAT, 32'h0);
      k++;
    end
    while (!(rd[10:8] === 3'h0 && rd[7] === 1'b1) && k < 400);
    chk("shifter_done", {28'h0, rd[10:7]}, 32'h1);
  endtask

  // One mode 0 word as link master: 160 ns clock, MSB first, data out taken on rise
  task automatic slv_xfer(input logic [7:0] b, output logic [7:0] o);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_m <= b[i];
      repeat (8) @(posedge pclk);
      o      = {o[6:0], pin_drive.serial_out_pin};
      sck_m  <= 1'b1;
      repeat (8) @(posedge pclk);
      sck_m  <= 1'b0;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far above the roughly 1700 cycles the tests take
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("stat_reset", `SSC_OFF_STAT, 32'h00a0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, `SSC_OFF_STAT, 32'h5800);
    rd_chk("stat_reserved", `SSC_OFF_STAT, 32'h00a0);
    apb(1'b1, `SSC_OFF_STAT, 32'h2000);
    rd_chk("stat_sidl", `SSC_OFF_STAT, 32'h20a0);
    $display("test registers done");

    // Standard master: each select code fires its own event
    apb(1'b1, `SSC_OFF_CTRL, 32'h1);
    apb(1'b1, `SSC_OFF_IMASK, 32'h3);
    foreach (sels[i])
    begin
      apb(1'b1, `SSC_OFF_STAT, {16'h0, 16'h8000 | {11'h0, sels[i], 2'h0}});
      send();
      wait_irq();
      rd_chk("istat_sel", `SSC_OFF_ISTAT, 32'h1);
      wait_done();
      rd_chk("rx_word", `SSC_OFF_DATA, {24'h0, q.pop_front()});
    end
    $display("test select codes done");

    // Second word completes while the first is unread
    send();
    wait_done();
    send();
    wait_done();
    void'(q.pop_back());
    rd_chk("istat_ovf", `SSC_OFF_ISTAT, 32'h3);
    rd_chk("stat_ovf", `SSC_OFF_STAT, 32'h80d5);
    rd_chk("rx_kept", `SSC_OFF_DATA, {24'h0, q.pop_front()});
    rd_chk("stat_popped", `SSC_OFF_STAT, 32'h80f4);
    apb(1'b1, `SSC_OFF_STAT, 32'h8014);
    rd_chk("stat_ovf_clr", `SSC_OFF_STAT, 32'h80b4);
    $display("test overflow done");

    // Enhanced master held by idle: words queue, count shows them
    apb(1'b1, `SSC_OFF_STAT, 32'h0);
    apb(1'b1, `SSC_OFF_CTRL, 32'h3);
    apb(1'b1, `SSC_OFF_IMASK, 32'h1);
    cpu_idle <= 1'b1;
    apb(1'b1, `SSC_OFF_STAT, 32'ha01c);
    repeat (4) send();
    chk("master_oe", {30'h0, pin_drive.serial_clock_oe, pin_drive.serial_out_oe}, 32'h3);
    rd_chk("stat_halted", `SSC_OFF_STAT, 32'ha4be);
    rd_chk("istat_tx_full", `SSC_OFF_ISTAT, 32'h1);
    apb(1'b1, `SSC_OFF_STAT, 32'ha000);
    cpu_idle <= 1'b0;
    // Idle again in mid-word: the shifter must freeze, then finish
    repeat (20) @(posedge pclk);
    cpu_idle <= 1'b1;
    repeat (40) @(posedge pclk);
    cpu_idle <= 1'b0;
    wait_done();
    rd_chk("stat_rx_full", `SSC_OFF_STAT, 32'ha081);
    repeat (4) rd_chk("rx_fifo", `SSC_OFF_DATA, {24'h0, q.pop_front()});
    wait_irq();
    rd_chk("istat_rx_empty", `SSC_OFF_ISTAT, 32'h1);
    rd_chk("stat_drained", `SSC_OFF_STAT, 32'ha0a0);
    $display("test enhanced done");

    // Enhanced slave: bench drives the link, two words chain under select
    apb(1'b1, `SSC_OFF_STAT, 32'h0);
    apb(1'b1, `SSC_OFF_CTRL, 32'h2);
    apb(1'b1, `SSC_OFF_STAT, 32'h8004);
    foreach (sb[i])
    begin
      seed  = lfsr(seed);
      sb[i] = seed;
    end
    apb(1'b1, `SSC_OFF_DATA, {24'h0, sb[0]});
    slave <= 1'b1;
    ss_n  <= 1'b0;
    slv_xfer(sb[1], got);
    chk("slave_tx", {24'h0, got}, {24'h0, sb[0]});
    chk("slave_oe", {30'h0, pin_drive.serial_clock_oe, pin_drive.serial_out_oe}, 32'h1);
    slv_xfer(sb[2], got);
    // Let the last falling edge through the synchroniser before release
    repeat (4) @(posedge pclk);
    ss_n <= 1'b1;
    wait_irq();
    rd_chk("istat_rx_any", `SSC_OFF_ISTAT, 32'h1);
    rd_chk("stat_slave", `SSC_OFF_STAT, 32'h8284);
    rd_chk("slave_rx0", `SSC_OFF_DATA, {24'h0, sb[1]});
    rd_chk("slave_rx1", `SSC_OFF_DATA, {24'h0, sb[2]});
    chk("slave_oe_off", {30'h0, pin_drive.serial_clock_oe, pin_drive.serial_out_oe}, 32'h0);
    $display("test slave done");
    summarize();
  end
endmodule
